//--- rtl/ptlfb_pkg.sv
// Package of constants and types for the PCI target lock and fast back-to-back logic
package ptlfb_pkg;
  // Command codes on the command/byte-enable lines during the address phase
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  // Default address decode window
  localparam logic [31:0] BAR_BASE_DEF = 32'h1000_0000;
  localparam logic [31:0] BAR_MASK_DEF = 32'hffff_0000;
  // Width of the initiator identity carried with each access
  localparam int INIT_ID_W = 4;
  // Reset values of the target's bus outputs (inactive, not driven)
  localparam logic TGT_OUT_RST = 1'b1;
  localparam logic TGT_OE_RST  = 1'b1;
  // Target bus states
  typedef enum logic [2:0] {
    PTL_IDLE = 3'b000,  // Waiting for an address phase
    PTL_DATA = 3'b001,  // Claimed, moving read or write data
    PTL_RTRY = 3'b010,  // Retry termination in progress
    PTL_TURN = 3'b011   // Driving outputs inactive for one cycle
  } ptl_state_t;
endpackage

//--- rtl/ptlfb_target.sv
// PCI target with exclusive lock handling and fast back-to-back write acceptance
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Locked target refuses accesses from other initiators
// - Owner re-access with LOCK deasserted keeps lock
// - LOCK and FRAME both deasserted clears lock
// - Decode same-target back-to-back writes correctly
// - Claim with DEVSEL, TRDY when data accepted
// - Last element clock: negate TRDY and DEVSEL
// - Negated TRDY inserts wait states until reasserted
// - Outputs driven inactive one cycle, then released
module ptlfb_target
  import ptlfb_pkg::*;
#(
  parameter logic [31:0] BAR_BASE   = BAR_BASE_DEF,  // Decode base
  parameter logic [31:0] BAR_MASK   = BAR_MASK_DEF,  // Decode mask
  parameter int          WAIT_EVERY = 2               // Wait state after every Nth element
) (
  input  wire logic                 mclk,                      // 250 MHz bus-logic clock
  input  wire logic                 rst_n,                     // Asynchronous reset
  input  wire logic                 pci_frame_n,               // Cycle frame, active low
  input  wire logic                 pci_initiator_ready_n,     // Initiator ready
  input  wire logic                 pci_lock_n,                // Exclusive lock
  input  wire logic [31:0]          pciAdIn,                   // Address/data bus in
  input  wire logic [3:0]           pci_cmd_byte_en_n,         // Command / byte enables
  input  wire logic [INIT_ID_W-1:0] initId,                    // Current bus owner identity
  output logic                      pciTargetReadyOut,         // TRDY drive level
  output logic                      pciTargetReadyOe_n,        // TRDY enable, low drives
  output logic                      pciDeviceSelectOut,        // DEVSEL drive level
  output logic                      pciDeviceSelectOe_n,       // DEVSEL enable, low drives
  output logic                      pciStopOut,                // STOP drive level
  output logic                      pciStopOe_n,               // STOP enable, low drives
  output logic                      wrValid,                   // Element latched, read or write
  output logic [31:0]               wrAddr,                    // Its address
  output logic [31:0]               wrData,                    // Its data
  output logic [3:0]                wrByteEn,                  // Its byte enables, active high
  output logic                      locked                     // Target lock held
);

  // Refuse a wait spacing the counter cannot represent
  if (WAIT_EVERY < 1 || WAIT_EVERY > 15) begin : gen_wait_check
    $error("WAIT_EVERY out of range");
  end

  // State, address counter, lock owner and wait pacing
  ptl_state_t           state,   next_state;
  logic [31:0]          addr,    next_addr;
  logic [INIT_ID_W-1:0] owner,   next_owner;
  logic                 next_locked;
  logic [3:0]           pace,    next_pace;      // Elements since last wait
  logic                 lockPend, next_lockPend; // Locked read started, awaiting data
  logic                 frameHist_n;             // FRAME level at the previous edge
  logic                 next_trdy, next_devsel, next_stop, next_oe;
  logic                 next_wrValid;
  logic [31:0]          next_wrData;
  logic [3:0]           next_wrBe;

  // Decode of an address phase aimed at this target
  logic addrPhase, hit, isWrite, isRead, foreign;
  // Only the first clock of FRAME low is an address phase, so data words of
  // bursts aimed at other targets are never mistaken for addresses
  assign addrPhase = !pci_frame_n && frameHist_n && (state == PTL_IDLE || state == PTL_TURN);
  assign hit       = (pciAdIn & BAR_MASK) == (BAR_BASE & BAR_MASK);
  assign isWrite   = pci_cmd_byte_en_n == CMD_MEM_WRITE;
  assign isRead    = pci_cmd_byte_en_n == CMD_MEM_READ;
  assign foreign   = locked && initId != owner;

  // Handshake of the current data phase
  logic xfer;
  assign xfer = !pciTargetReadyOut && !pci_initiator_ready_n;

  // Next-state logic for the target bus machine and lock
  always_comb begin
    next_state    = state;
    next_addr     = addr;
    next_owner    = owner;
    next_locked   = locked;
    next_pace     = pace;
    next_lockPend = lockPend;
    next_trdy     = 1'b1;
    next_devsel   = 1'b1;
    next_stop     = 1'b1;
    next_oe       = 1'b1;
    next_wrValid  = 1'b0;
    next_wrData   = wrData;
    next_wrBe     = wrByteEn;
    // Idle bus with LOCK and FRAME both high ends the lock
    if (locked && pci_lock_n && pci_frame_n && state == PTL_IDLE) begin
      next_locked = 1'b0;
    end
    unique case (state)
      PTL_IDLE, PTL_TURN: begin
        // TURN already drove inactive levels; a new frame may start here (back-to-back)
        if (addrPhase && hit && (isWrite || isRead)) begin
          if (foreign) begin
            next_state = PTL_RTRY;
            next_stop  = 1'b0;
            next_oe    = 1'b0;
            next_devsel = 1'b0;
          end else begin
            // Owner re-access with LOCK high keeps the lock in place
            next_lockPend = isRead && !locked && !pci_lock_n;
            next_state  = PTL_DATA;
            next_addr   = pciAdIn;
            next_devsel = 1'b0;
            next_trdy   = 1'b0;
            next_oe     = 1'b0;
            next_pace   = 4'h0;
            if (next_lockPend) begin
              next_owner = initId;
            end
          end
        end else begin
          next_state = PTL_IDLE;
        end
      end
      PTL_DATA: begin
        next_oe     = 1'b0;
        next_devsel = 1'b0;
        if (xfer) begin
          // Element latched; report it and advance the burst address
          next_wrValid = 1'b1;
          next_wrData  = pciAdIn;
          next_wrBe    = ~pci_cmd_byte_en_n;
          next_addr    = addr + 32'h4;
          next_pace    = pace + 4'h1;
          if (lockPend) begin
            next_locked   = 1'b1;  // Lock taken once the data phase completes
            next_lockPend = 1'b0;
          end
          if (pci_frame_n) begin
            // Last element: drive inactive for one cycle
            next_state  = PTL_TURN;
            next_devsel = 1'b1;
            next_trdy   = 1'b1;
          end else if (pace + 4'h1 >= 4'(WAIT_EVERY)) begin
            next_trdy = 1'b1;
            next_pace = 4'h0;
          end else begin
            next_trdy = 1'b0;
          end
        end else begin
          // Wait state ends by reasserting TRDY
          next_trdy = 1'b0;
        end
      end
      PTL_RTRY: begin
        // Hold STOP until FRAME is released, then drive inactive one cycle
        next_oe = 1'b0;
        if (pci_frame_n) begin
          next_state = PTL_TURN;
        end else begin
          next_stop   = 1'b0;
          next_devsel = 1'b0;
        end
      end
      default: begin
        next_state = PTL_IDLE;
      end
    endcase
    // Lock request aborted before data completed
    if (lockPend && pci_lock_n && pci_frame_n && state != PTL_DATA) begin
      next_lockPend = 1'b0;
    end
  end

  // Registers of the target machine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= PTL_IDLE;
      addr                <= 32'h0000_0000;
      owner               <= '0;
      locked              <= 1'b0;
      pace                <= 4'h0;
      lockPend            <= 1'b0;
      frameHist_n         <= 1'b1;
      pciTargetReadyOut   <= TGT_OUT_RST;
      pciDeviceSelectOut  <= TGT_OUT_RST;
      pciStopOut          <= TGT_OUT_RST;
      pciTargetReadyOe_n  <= TGT_OE_RST;
      pciDeviceSelectOe_n <= TGT_OE_RST;
      pciStopOe_n         <= TGT_OE_RST;
      wrValid             <= 1'b0;
      wrAddr              <= 32'h0000_0000;
      wrData              <= 32'h0000_0000;
      wrByteEn            <= 4'h0;
    end else begin
      state               <= next_state;
      addr                <= next_addr;
      owner               <= next_owner;
      locked              <= next_locked;
      pace                <= next_pace;
      lockPend            <= next_lockPend;
      frameHist_n         <= pci_frame_n;
      pciTargetReadyOut   <= next_trdy;
      pciDeviceSelectOut  <= next_devsel;
      pciStopOut          <= next_stop;
      pciTargetReadyOe_n  <= next_oe;
      pciDeviceSelectOe_n <= next_oe;
      pciStopOe_n         <= next_oe;
      wrValid             <= next_wrValid;
      wrAddr              <= addr;
      wrData              <= next_wrData;
      wrByteEn            <= next_wrBe;
    end
  end

  // Foreign initiator never gets a data handshake while locked
  retry_no_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state == PTL_RTRY |-> pciTargetReadyOut)
    else $error("TRDY asserted during retry");
  foreign_refused_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (addrPhase && hit && isWrite && foreign) |=> !pciStopOut && pciTargetReadyOut)
    else $error("Locked target did not refuse foreign access");
  lock_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (locked && addrPhase && !foreign && pci_lock_n) |=> locked)
    else $error("Lock dropped on owner re-access");
  lock_cleared_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (locked && pci_lock_n && pci_frame_n && state == PTL_IDLE) |=> !locked)
    else $error("Lock not cleared on idle bus");
  claim_devsel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (addrPhase && hit && isWrite && !foreign) |=> !pciDeviceSelectOut && !pciTargetReadyOut)
    else $error("Decoded access not claimed");
  last_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PTL_DATA && xfer && pci_frame_n) |=> pciTargetReadyOut && pciDeviceSelectOut
      && !pciTargetReadyOe_n)
    else $error("TRDY/DEVSEL not negated on last element");
  turn_then_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PTL_TURN && pci_frame_n) |=> pciTargetReadyOe_n && pciDeviceSelectOe_n)
    else $error("Outputs not released after turnaround");
  wait_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PTL_DATA && pciTargetReadyOut) |=> !wrValid)
    else $error("Element latched during wait state");
  b2b_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PTL_TURN && addrPhase && hit && isWrite && !foreign) |=> state == PTL_DATA)
    else $error("Back-to-back write not decoded");

endmodule
`default_nettype wire

//--- sim/ptlfb_init_model.sv
// Behavioural PCI initiator that drives the target's bus inputs
`timescale 1ns/100ps
`default_nettype none
module ptlfb_init_model
  import ptlfb_pkg::*;
(
  input  wire logic                 mclk,    // Bus clock
  input  wire logic                 trdyW,   // TRDY wire level
  input  wire logic                 stopW,   // STOP wire level
  input  wire logic [31:0]          key,     // Data pattern key
  output logic                      frameN,  // FRAME drive
  output logic                      irdyN,   // IRDY drive
  output logic                      lockN,   // LOCK drive
  output logic [31:0]               ad,      // AD drive
  output logic [3:0]                cbeN,    // Command or byte enables
  output logic [INIT_ID_W-1:0]      id       // Owner identity
);
  // Bus idle until the first transaction
  initial begin
    {frameN, irdyN, lockN, ad, cbeN, id} = {3'h7, 32'h0, 4'hf, 4'h0};
  end

  // One transaction; the last element is left standing so a new address may follow
  task automatic xfer(input logic [31:0] a, input logic [3:0] cmd, input int n,
                      input logic lk, input logic [INIT_ID_W-1:0] who,
                      input logic slow, output int cyc, output logic stp);
    int i;
    i = 0;
    cyc = 0;
    stp = 1'b0;
    {frameN, irdyN} <= 2'b01;
    {ad, cbeN, lockN, id} <= {a, cmd, lk, who};
    @(posedge mclk);
    {ad, cbeN, frameN, irdyN} <= {a ^ key, ~key[3:0], n == 1, slow};
    while (i < n && cyc >= 0) begin
      @(posedge mclk);
      cyc++;
      if (!trdyW && !irdyN) i++;
      // Retry or no claim ends the attempt; the limit stands in for master abort
      if (!stopW || cyc > 20) begin
        stp = !stopW;
        cyc = -1;
        {frameN, irdyN} <= 2'b11;
      end else if (i < n) begin
        {ad, frameN, irdyN} <= {(a + 32'(4 * i)) ^ key, i == n - 1, 1'b0};
      end
    end
  endtask

  // Released lines show a changing pattern, never the last value
  task automatic idle(input logic lk);
    {frameN, irdyN, lockN} <= {2'b11, lk};
    ad <= ~ad;
    cbeN <= ~cbeN;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the PCI target lock and fast back-to-back logic
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ptlfb_pkg::*;
;
  localparam int WE = 2;                       // Elements between wait states
  logic                 mclk = 1'b0;           // Bus clock
  logic                 rst_n;                 // Reset, active low
  logic [31:0]          key;                   // Data pattern key
  logic                 frameN, irdyN, lockN;  // Initiator controls
  logic [31:0]          ad, wrAddr, wrData;    // Bus and latched element
  logic [3:0]           cbeN, wrByteEn;        // Enables
  logic [INIT_ID_W-1:0] id;                    // Owner identity
  logic                 trdyO, trdyE, devO, devE, stpO, stpE, wrValid, locked;
  logic [35:0]          expQ[$];               // Expected elements
  logic [35:0]          e;                     // Element under compare
  int                   nTab[3] = '{1, 4, 3};  // Burst lengths
  int                   errTotal = 0;          // Mismatches
  int                   samplesChecked = 0;    // Comparisons
  // Pull-ups hold released lines inactive
  wire logic            trdyW = trdyE ? 1'b1 : trdyO;
  wire logic            stopW = stpE ? 1'b1 : stpO;

  always #2 mclk = ~mclk;

  ptlfb_target #(.WAIT_EVERY(WE)) uut (.mclk(mclk), .rst_n(rst_n), .pci_frame_n(frameN),
    .pci_initiator_ready_n(irdyN), .pci_lock_n(lockN), .pciAdIn(ad),
    .pci_cmd_byte_en_n(cbeN), .initId(id), .pciTargetReadyOut(trdyO),
    .pciTargetReadyOe_n(trdyE), .pciDeviceSelectOut(devO), .pciDeviceSelectOe_n(devE),
    .pciStopOut(stpO), .pciStopOe_n(stpE), .wrValid(wrValid), .wrAddr(wrAddr),
    .wrData(wrData), .wrByteEn(wrByteEn), .locked(locked));
  ptlfb_init_model partner (.mclk(mclk), .trdyW(trdyW), .stopW(stopW), .key(key),
    .frameN(frameN), .irdyN(irdyN), .lockN(lockN), .ad(ad), .cbeN(cbeN), .id(id));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      errTotal++;
    end
  endtask

  task automatic testDone();
    $display("compares %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Queue what the target should latch, then run the access
  task automatic go(input logic [31:0] a, input logic [3:0] cmd, input int n, input logic lk,
                    input logic [3:0] who, input logic slow, input logic take,
                    output int c, output logic s);
    for (int i = 0; i < n; i++) if (take) expQ.push_back({cmd, a + 32'(4 * i)});
    partner.xfer(a, cmd, n, lk, who, slow, c, s);
  endtask

  // Reference compare of every latched element; reads carry no initiator data
  always @(posedge mclk) begin
    if (wrValid === 1'b1) begin
      if (expQ.size() == 0) begin
        chk(1, 0);
      end else begin
        e = expQ.pop_front();
        chk(wrAddr, e[31:0]);
        chk(wrByteEn, key[3:0]);
        if (e[35:32] == CMD_MEM_WRITE) chk(wrData, e[31:0] ^ key);
      end
    end
  end

  initial begin
    int c;
    logic s;
    logic sl;
    logic [3:0] own;
    rst_n = 1'b0;
    void'($urandom(32'h3df1));
    key = $urandom;
    repeat (6) @(posedge mclk);
    chk({locked, wrValid, trdyO, trdyE, devO, devE, stpO, stpE}, 8'h3f);
    rst_n <= 1'b1;
    @(posedge mclk);
    // Writes chained with no idle cycle; each burst pays its wait states
    foreach (nTab[k]) begin
      sl = 1'($urandom);
      go(BAR_BASE_DEF + ($urandom % 256) * 16, CMD_MEM_WRITE, nTab[k], 1'b1, 4'($urandom), sl,
         1'b1, c, s);
      chk(c, nTab[k] + (nTab[k] - 1) / WE + sl);
    end
    partner.idle(1'b1);
    chk({trdyO, devO, stpO, trdyE}, 4'he);
    partner.idle(1'b1);
    chk({trdyE, devE, stpE}, 3'h7);
    // Slow initiator holds back its first element
    go(BAR_BASE_DEF + 32'h40, CMD_MEM_WRITE, 2, 1'b1, 4'($urandom), 1'b1, 1'b1, c, s);
    chk(c, 2 + (2 - 1) / WE + 1);
    partner.idle(1'b1);
    // Wrong command, then an address outside the window: neither is claimed
    for (int k = 0; k < 2; k++) begin
      go(k ? 32'h2000_0000 : BAR_BASE_DEF, k ? CMD_MEM_WRITE : 4'($urandom % 6), 1, 1'b1,
         4'($urandom), 1'b0, 1'b0, c, s);
      chk(c + s, -1);
      partner.idle(1'b1);
    end
    // Lock by a read, refuse a stranger, keep it for the owner, then let go
    own = 4'($urandom);
    go(BAR_BASE_DEF, CMD_MEM_READ, 1, 1'b0, own, 1'b0, 1'b1, c, s);
    repeat (2) partner.idle(1'b0);
    chk(locked, 1);
    go(BAR_BASE_DEF + 32'h80, CMD_MEM_WRITE, 1, 1'b0, own ^ 4'(1 + $urandom % 15), 1'b0,
       1'b0, c, s);
    chk(s, 1);
    repeat (2) partner.idle(1'b0);
    go(BAR_BASE_DEF + 32'h90, CMD_MEM_WRITE, 2, 1'b1, own, 1'b0, 1'b1, c, s);
    chk(locked, 1);
    repeat (3) partner.idle(1'b1);
    chk(locked, 0);
    chk(expQ.size(), 0);
    testDone();
  end

  // Hang guard
  initial begin
    #60000;
    chk(0, 1);
    testDone();
  end
endmodule
`default_nettype wire
